// ### hdl/cpu_slice_pkg.sv
// Constants, register map and carrier types for the stack/rotate slice
package cpu_slice_pkg;

  // Opcodes of the slice
  localparam logic [7:0] OPC_PUSH_R = 8'h70;
  localparam logic [7:0] OPC_PUSH_IR = 8'h71;
  localparam logic [7:0] OPC_STORE_DOWN = 8'h82;
  localparam logic [7:0] OPC_STORE_UP = 8'h83;
  localparam logic [7:0] OPC_CLEAR_CARRY = 8'hcf;
  localparam logic [7:0] OPC_SUB_EXIT = 8'haf;
  localparam logic [7:0] OPC_ROL_R = 8'h90;
  localparam logic [7:0] OPC_ROL_IR = 8'h91;
  localparam logic [7:0] OPC_ROLC_R = 8'h10;
  localparam logic [7:0] OPC_ROLC_IR = 8'h11;
  localparam logic [7:0] OPC_ROR_R = 8'he0;
  localparam logic [7:0] OPC_ROR_IR = 8'he1;

  // Flag bit positions
  localparam int unsigned FLAG_C = 7;
  localparam int unsigned FLAG_Z = 6;
  localparam int unsigned FLAG_S = 5;
  localparam int unsigned FLAG_V = 4;

  // Instruction lengths in cycles and in bytes
  localparam logic [3:0] CYC_LONG = 4'h8;
  localparam logic [3:0] CYC_SHORT = 4'h4;
  localparam logic [3:0] CYC_EXIT_EXT = 4'ha;
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [3:0] STEP_0 = 4'h0;
  localparam logic [3:0] STEP_1 = 4'h1;
  localparam logic [3:0] STEP_2 = 4'h2;
  localparam logic [3:0] STEP_3 = 4'h3;
  localparam logic [15:0] LEN_1 = 16'h0001;
  localparam logic [15:0] LEN_2 = 16'h0002;
  localparam logic [15:0] LEN_3 = 16'h0003;
  localparam logic [15:0] SP_STEP = 16'h0001;
  localparam logic [15:0] SP_EXIT_STEP = 16'h0002;
  localparam logic [7:0] PTR_STEP = 8'h01;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_SP = 8'h0c;
  localparam logic [7:0] ADDR_PC = 8'h10;
  localparam logic [7:0] ADDR_INSTR = 8'h14;
  localparam logic [7:0] ADDR_RF_ADDR = 8'h18;
  localparam logic [7:0] ADDR_RF_DATA = 8'h1c;

  // Reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;

  typedef enum logic [3:0] {
    K_PUSH, K_DOWN, K_UP, K_CLC, K_EXIT, K_ROL, K_ROLC, K_ROR, K_BAD
  } op_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } stack_req_type;

  typedef struct packed {
    logic [7:0] raddr;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic we;
  } rf_port_type;

  typedef struct packed {
    logic busy;
    op_type kind;
    logic ind;
    logic [7:0] opc;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [3:0] cyc;
    logic [3:0] last;
    logic [15:0] plen;
    logic [7:0] ta;
    logic [7:0] td;
    logic [7:0] flags;
    logic [15:0] sp;
    logic [15:0] pc;
    logic ext_stack;
    logic bad;
    logic rf_hold;
    logic [7:0] rf_addr;
  } exec_state_type;

endpackage

// ### hdl/regfile_mem.sv
// 256-byte register file with one write port and a registered read port
module regfile_mem
  import cpu_slice_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire rf_port_type port,
  output logic [7:0] rdata
);

  typedef struct packed {
    logic [255:0][7:0] cells;
    logic [7:0] rdata;
  } mem_state_type;

  mem_state_type mem_reg;
  mem_state_type mem_next;

  // Read returns the old byte when the same cell is written in that cycle
  always_comb begin
    mem_next = mem_reg;
    mem_next.rdata = mem_reg.cells[port.raddr];
    if (port.we) begin
      mem_next.cells[port.waddr] = port.wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_reg <= '0;
    end else begin
      mem_reg <= mem_next;
    end
  end

  assign rdata = mem_reg.rdata;

endmodule

// ### hdl/stack_rotate_instr_exec.sv
// Executes push, user-stack stores, clear-carry, return and rotates
module stack_rotate_instr_exec
  import cpu_slice_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire apb_req_type apb_req,
  output apb_rsp_type apb_rsp,
  output stack_req_type stack_req,
  input wire logic [7:0] stack_rdata,
  output logic [15:0] fetch_addr,
  output logic instr_done
);

  exec_state_type st_reg;
  exec_state_type st_next;
  rf_port_type rf;
  logic [7:0] rf_rdata;
  logic [7:0] rot_res;
  logic rot_c;
  logic done;
  logic acc;
  logic wr_ok;

  regfile_mem u_regfile (
    .clk(clk),
    .rst(rst),
    .port(rf),
    .rdata(rf_rdata)
  );

  // Rotate datapath; the operand is always the register file read data
  always_comb begin
    rot_res = rf_rdata;
    rot_c = 1'b0;
    case (st_reg.kind)
      K_ROL: begin
        rot_res = {rf_rdata[6:0], rf_rdata[7]};
        rot_c = rf_rdata[7];
      end
      K_ROLC: begin
        rot_res = {rf_rdata[6:0], st_reg.flags[FLAG_C]};
        rot_c = rf_rdata[7];
      end
      K_ROR: begin
        rot_res = {rf_rdata[0], rf_rdata[7:1]};
        rot_c = rf_rdata[0];
      end
      default: begin
        rot_res = rf_rdata;
        rot_c = 1'b0;
      end
    endcase
  end

  assign done = st_reg.busy && (st_reg.cyc == st_reg.last);
  assign acc = apb_req.psel && apb_req.penable;
  assign wr_ok = acc && apb_req.pwrite && !st_reg.busy;

  // Next state: instruction sequencing, then the APB slave
  always_comb begin
    st_next = st_reg;
    rf = '0;
    stack_req = '0;
    apb_rsp = '0;
    apb_rsp.pready = 1'b1;
    if (st_reg.busy) begin
      st_next.cyc = st_reg.cyc + CYC_ONE;
      case (st_reg.kind)
        K_PUSH, K_ROL, K_ROLC, K_ROR: begin
          if (st_reg.cyc == STEP_0) begin
            rf.raddr = st_reg.b1;
          end else if (st_reg.cyc == STEP_1) begin
            // Indirect forms address through the register contents
            st_next.ta = st_reg.ind ? rf_rdata : st_reg.b1;
            rf.raddr = st_next.ta;
          end else if (st_reg.cyc == STEP_2) begin
            if (st_reg.kind == K_PUSH) begin
              // Decrement first, store at the lowered pointer
              st_next.sp = st_reg.sp - SP_STEP;
              stack_req.we = 1'b1;
              stack_req.addr = st_next.sp;
              stack_req.wdata = rf_rdata;
            end else begin
              rf.we = 1'b1;
              rf.waddr = st_reg.ta;
              rf.wdata = rot_res;
              st_next.flags[FLAG_C] = rot_c;
              st_next.flags[FLAG_Z] = (rot_res == '0);
              st_next.flags[FLAG_S] = rot_res[7];
              // Sign change; for the plain left rotate this is overflow
              st_next.flags[FLAG_V] = rot_res[7] ^ rf_rdata[7];
            end
          end
        end
        K_DOWN, K_UP: begin
          if (st_reg.cyc == STEP_0) begin
            rf.raddr = st_reg.b2;
          end else if (st_reg.cyc == STEP_1) begin
            st_next.td = rf_rdata;
            rf.raddr = st_reg.b1;
          end else if (st_reg.cyc == STEP_2) begin
            // Pointer register is updated before the data store
            st_next.ta = (st_reg.kind == K_DOWN) ?
              rf_rdata - PTR_STEP : rf_rdata + PTR_STEP;
            rf.we = 1'b1;
            rf.waddr = st_reg.b1;
            rf.wdata = st_next.ta;
          end else if (st_reg.cyc == STEP_3) begin
            // Target is inside the register file, not the system stack
            rf.we = 1'b1;
            rf.waddr = st_reg.ta;
            rf.wdata = st_reg.td;
          end
        end
        K_EXIT: begin
          if (st_reg.cyc == STEP_0) begin
            stack_req.re = 1'b1;
            stack_req.addr = st_reg.sp;
          end else if (st_reg.cyc == STEP_1) begin
            st_next.td = stack_rdata;
            stack_req.re = 1'b1;
            stack_req.addr = st_reg.sp + SP_STEP;
          end else if (st_reg.cyc == STEP_2) begin
            st_next.pc = {st_reg.td, stack_rdata};
            st_next.sp = st_reg.sp + SP_EXIT_STEP;
          end
        end
        K_CLC: begin
          if (st_reg.cyc == STEP_0) begin
            st_next.flags[FLAG_C] = 1'b0;
          end
        end
        default: begin
          st_next.bad = 1'b1;
        end
      endcase
      // Return already loaded its target, so only others step the counter
      if (done) begin
        st_next.busy = 1'b0;
        if (st_reg.kind != K_EXIT) begin
          st_next.pc = st_reg.pc + st_reg.plen;
        end
      end
    end

    // APB register file window: reads take one extra cycle, and wait
    // while an instruction owns the register file
    if (acc && (apb_req.paddr == ADDR_RF_DATA)) begin
      if (apb_req.pwrite) begin
        apb_rsp.pready = !st_reg.busy;
        if (!st_reg.busy) begin
          rf.we = 1'b1;
          rf.waddr = st_reg.rf_addr;
          rf.wdata = apb_req.pwdata[7:0];
        end
      end else begin
        apb_rsp.pready = !st_reg.busy && st_reg.rf_hold;
        st_next.rf_hold = !st_reg.busy && !st_reg.rf_hold;
        if (!st_reg.busy) begin
          rf.raddr = st_reg.rf_addr;
        end
      end
    end

    // Read mux; address decode as a priority chain
    if (apb_req.paddr == ADDR_CTRL) begin
      apb_rsp.prdata = {31'h00000000, st_reg.ext_stack};
    end else if (apb_req.paddr == ADDR_STATUS) begin
      apb_rsp.prdata = {30'h00000000, st_reg.bad, st_reg.busy};
    end else if (apb_req.paddr == ADDR_FLAGS) begin
      apb_rsp.prdata = {24'h000000, st_reg.flags};
    end else if (apb_req.paddr == ADDR_SP) begin
      apb_rsp.prdata = {16'h0000, st_reg.sp};
    end else if (apb_req.paddr == ADDR_PC) begin
      apb_rsp.prdata = {16'h0000, st_reg.pc};
    end else if (apb_req.paddr == ADDR_INSTR) begin
      apb_rsp.prdata = {8'h00, st_reg.b2, st_reg.b1, st_reg.opc};
    end else if (apb_req.paddr == ADDR_RF_ADDR) begin
      apb_rsp.prdata = {24'h000000, st_reg.rf_addr};
    end else if (apb_req.paddr == ADDR_RF_DATA) begin
      apb_rsp.prdata = {24'h000000, rf_rdata};
    end else begin
      apb_rsp.pslverr = acc;
    end

    // Writes to architectural state are dropped while busy, except register file window
    // writes, which wait for the instruction; so software cannot tear an instruction in flight
    if (wr_ok) begin
      if (apb_req.paddr == ADDR_CTRL) begin
        st_next.ext_stack = apb_req.pwdata[0];
      end else if (apb_req.paddr == ADDR_FLAGS) begin
        st_next.flags = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == ADDR_SP) begin
        st_next.sp = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == ADDR_PC) begin
        st_next.pc = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == ADDR_RF_ADDR) begin
        st_next.rf_addr = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == ADDR_INSTR) begin
        st_next.busy = 1'b1;
        st_next.bad = 1'b0;
        st_next.cyc = STEP_0;
        st_next.opc = apb_req.pwdata[7:0];
        st_next.b1 = apb_req.pwdata[15:8];
        st_next.b2 = apb_req.pwdata[23:16];
        st_next.ind = apb_req.pwdata[0];
        st_next.last = CYC_SHORT - CYC_ONE;
        st_next.plen = LEN_2;
        case (apb_req.pwdata[7:0])
          OPC_PUSH_R, OPC_PUSH_IR: begin
            st_next.kind = K_PUSH;
            st_next.last = CYC_LONG - CYC_ONE;
          end
          OPC_STORE_DOWN, OPC_STORE_UP: begin
            st_next.kind = apb_req.pwdata[0] ? K_UP : K_DOWN;
            st_next.last = CYC_LONG - CYC_ONE;
            st_next.plen = LEN_3;
          end
          OPC_CLEAR_CARRY: begin
            st_next.kind = K_CLC;
            st_next.plen = LEN_1;
          end
          OPC_SUB_EXIT: begin
            st_next.kind = K_EXIT;
            st_next.plen = LEN_1;
            st_next.last = (st_reg.ext_stack ? CYC_EXIT_EXT : CYC_LONG)
              - CYC_ONE;
          end
          OPC_ROL_R, OPC_ROL_IR: begin
            st_next.kind = K_ROL;
          end
          OPC_ROLC_R, OPC_ROLC_IR: begin
            st_next.kind = K_ROLC;
          end
          OPC_ROR_R, OPC_ROR_IR: begin
            st_next.kind = K_ROR;
          end
          default: begin
            st_next.kind = K_BAD;
            st_next.plen = LEN_1;
          end
        endcase
      end
    end
  end

  // Single state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.kind <= K_BAD;
      st_reg.flags <= FLAGS_RESET;
      st_reg.sp <= SP_RESET;
      st_reg.pc <= PC_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fetch_addr = st_reg.pc;
  assign instr_done = done;

  // Helper terms for the checks below
  logic step2;
  logic rot_wr;
  assign step2 = st_reg.busy && (st_reg.cyc == STEP_2);
  assign rot_wr = rf.we && step2 &&
    (st_reg.kind inside {K_ROL, K_ROLC, K_ROR});

  // Instruction length by kind, kept apart from the decoder's own table
  logic [15:0] len_exp;
  assign len_exp = (st_reg.kind inside {K_DOWN, K_UP}) ? LEN_3 :
    (st_reg.kind inside {K_CLC, K_BAD}) ? LEN_1 : LEN_2;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_push_sp_down: assert property (
    stack_req.we |-> stack_req.addr == st_reg.sp - SP_STEP
      ##1 st_reg.sp == $past(stack_req.addr))
    else $error("push did not store at the lowered stack pointer");

  chk_flags_kept: assert property (
    (st_reg.busy && st_reg.kind inside {K_PUSH, K_DOWN, K_UP, K_EXIT})
      |=> $stable(st_reg.flags))
    else $error("flags changed during a stack instruction");

  chk_store_ptr: assert property (
    (step2 && st_reg.kind == K_DOWN) |->
      rf.wdata == rf_rdata - PTR_STEP && rf.waddr == st_reg.b1
      ##1 rf.we && rf.waddr == $past(rf.wdata))
    else $error("store-down pointer or target wrong");

  chk_store_up: assert property (
    (step2 && st_reg.kind == K_UP) |->
      rf.wdata == rf_rdata + PTR_STEP && rf.waddr == st_reg.b1
      ##1 rf.we && rf.waddr == $past(rf.wdata))
    else $error("store-up pointer or target wrong");

  chk_user_target: assert property (
    (st_reg.busy && st_reg.kind inside {K_DOWN, K_UP} &&
     st_reg.cyc == STEP_3) |-> rf.we && !stack_req.we &&
      rf.waddr == $past(rf.wdata) && rf.wdata == $past(rf_rdata, 2))
    else $error("user-stack store missed the register file target");

  chk_pc_step: assert property (
    (instr_done && st_reg.kind != K_EXIT) |=>
      fetch_addr == $past(fetch_addr) + $past(len_exp))
    else $error("program counter did not advance by the length");

  chk_clear_carry: assert property (
    (st_reg.busy && st_reg.kind == K_CLC && st_reg.cyc == STEP_0) |=>
      !st_reg.flags[FLAG_C] &&
      st_reg.flags[6:0] == $past(st_reg.flags[6:0]))
    else $error("clear-carry result wrong");

  chk_exit_load: assert property (
    (step2 && st_reg.kind == K_EXIT) |=>
      st_reg.pc == {$past(stack_rdata, 2), $past(stack_rdata)} &&
      st_reg.sp == $past(st_reg.sp) + SP_EXIT_STEP)
    else $error("return loaded wrong program counter or pointer");

  chk_exit_time: assert property (
    (wr_ok && apb_req.paddr == ADDR_INSTR &&
     apb_req.pwdata[7:0] == OPC_SUB_EXIT && st_reg.ext_stack)
      |=> !instr_done [*8] ##1 !instr_done ##1 instr_done ##1 !st_reg.busy)
    else $error("return did not take ten cycles");

  chk_rotate_res: assert property (
    rot_wr |-> rf.wdata == ((st_reg.kind == K_ROL) ?
      {rf_rdata[6:0], rf_rdata[7]} : (st_reg.kind == K_ROLC) ?
      {rf_rdata[6:0], st_reg.flags[FLAG_C]} : {rf_rdata[0], rf_rdata[7:1]}))
    else $error("rotate result wrong");

  chk_rotate_flags: assert property (
    rot_wr |=> st_reg.flags[FLAG_C] == ($past(st_reg.kind) == K_ROR ?
      $past(rf_rdata[0]) : $past(rf_rdata[7])) &&
      st_reg.flags[FLAG_S] == $past(rf.wdata[7]) &&
      st_reg.flags[FLAG_Z] == ($past(rf.wdata) == 8'h00) &&
      st_reg.flags[3:0] == $past(st_reg.flags[3:0]))
    else $error("rotate flags wrong");

  chk_overflow: assert property (
    rot_wr |=> st_reg.flags[FLAG_V] ==
      ($past(rf_rdata[7]) != $past(rf.wdata[7])))
    else $error("rotate overflow wrong");

  cov_push: cover property (stack_req.we);
  cov_exit: cover property (instr_done && st_reg.kind == K_EXIT);
  cov_down: cover property (instr_done && st_reg.kind == K_DOWN);
  cov_rotc: cover property (rot_wr && st_reg.kind == K_ROLC);
  cov_bad: cover property (instr_done && st_reg.kind == K_BAD);

endmodule

// ### verification/stack_mem_model.sv
// Behavioural system stack memory seen on the slice's stack port
module stack_mem_model
  import cpu_slice_pkg::*;
(
  input wire logic clk,
  input wire stack_req_type stack_req,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [0:65535];

  // Synchronous RAM; read data is only good in the cycle after the strobe
  always @(posedge clk) begin
    if (stack_req.we) begin
      mem[stack_req.addr] <= stack_req.wdata;
    end
    if (stack_req.re) begin
      rdata <= mem[stack_req.addr];
    end else begin
      rdata <= ~rdata; // Stale data is not held, so a late sample shows up
    end
  end
endmodule

// ### verification/testbench.sv
// Self-checking bench for the stack and rotate execution slice
module testbench
  import cpu_slice_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] opc;
    logic [7:0] val;
    logic [7:0] fin;
    logic [7:0] res;
    logic [7:0] fout;
  } row_type;

  logic clk;
  logic rst;
  apb_req_type apb_req;
  apb_rsp_type apb_rsp;
  stack_req_type stack_req;
  logic [7:0] stack_rdata;
  logic [15:0] fetch_addr;
  logic instr_done;
  int errors;
  int check_count;
  logic [15:0] exp_pc;

  // Rotates and clear-carry: opcode, operand, flags in, result, flags out
  row_type rows [11] = '{
    {OPC_ROL_R, 8'haa, 8'h0a, 8'h55, 8'h9a},
    {OPC_ROL_R, 8'h00, 8'h8f, 8'h00, 8'h4f},
    {OPC_ROL_IR, 8'h17, 8'h00, 8'h2e, 8'h00},
    {OPC_ROLC_R, 8'haa, 8'h00, 8'h54, 8'h90},
    {OPC_ROLC_R, 8'h7f, 8'h80, 8'hff, 8'h30},
    {OPC_ROLC_IR, 8'h80, 8'h00, 8'h00, 8'hd0},
    {OPC_ROR_R, 8'h31, 8'h05, 8'h98, 8'hb5},
    {OPC_ROR_R, 8'h00, 8'hff, 8'h00, 8'h4f},
    {OPC_ROR_IR, 8'h02, 8'h00, 8'h01, 8'h00},
    {OPC_CLEAR_CARRY, 8'h00, 8'hff, 8'h00, 8'h7f},
    {OPC_CLEAR_CARRY, 8'h00, 8'h7f, 8'h00, 8'h7f}
  };

  stack_rotate_instr_exec dut (
    .clk(clk),
    .rst(rst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .stack_req(stack_req),
    .stack_rdata(stack_rdata),
    .fetch_addr(fetch_addr),
    .instr_done(instr_done)
  );

  stack_mem_model stack (
    .clk(clk),
    .stack_req(stack_req),
    .rdata(stack_rdata)
  );

  initial clk = 1'b0;
  always #4 clk = ~clk;

  task automatic conclude();
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                 pwdata: wd};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do @(posedge clk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, ex, r);
  endtask

  task automatic rf_set(input logic [7:0] a, input logic [7:0] v);
    wr(ADDR_RF_ADDR, {24'h0, a});
    wr(ADDR_RF_DATA, {24'h0, v});
  endtask

  task automatic rf_chk(input string nm, input logic [7:0] a,
                        input logic [7:0] ex);
    wr(ADDR_RF_ADDR, {24'h0, a});
    rdchk(nm, ADDR_RF_DATA, {24'h0, ex});
  endtask

  // Issue one instruction and count cycles up to its done pulse
  task automatic exec(input logic [23:0] ins, input logic [3:0] cyc);
    int n;
    n = 0;
    wr(ADDR_INSTR, {8'h00, ins});
    do begin
      @(negedge clk);
      n++;
    end while (instr_done !== 1'b1 && n < 16);
    chk("cycles", {28'h0, cyc}, n);
  endtask

  // Watchdog: the whole run needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude();
  end

  initial begin
    logic ind;
    row_type w;
    logic [31:0] r;
    logic er;
    rst = 1'b1;
    apb_req = '0;
    errors = 0;
    check_count = 0;
    exp_pc = PC_RESET;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdchk("flags", ADDR_FLAGS, {24'h0, FLAGS_RESET});
    rdchk("sp", ADDR_SP, {16'h0, SP_RESET});
    rdchk("status", ADDR_STATUS, 32'h0);
    // Table of rotates and carry clears, direct and indirect operands
    foreach (rows[i]) begin
      w = rows[i];
      ind = w.opc[0] && w.opc != OPC_CLEAR_CARRY;
      rf_set(8'h30, w.val);
      rf_set(8'h31, 8'h30);
      wr(ADDR_FLAGS, {24'h0, w.fin});
      exec({8'h00, ind ? 8'h31 : 8'h30, w.opc}, CYC_SHORT);
      rf_chk("result", 8'h30, w.res);
      apb(1'b0, ADDR_FLAGS, 32'h0, r, er);
      chk("flags", {24'h0, w.fout}, r);
      chk("zsv", 32'(w.fout[6:4]), 32'(r[6:4]));
      exp_pc = exp_pc + ((w.opc == OPC_CLEAR_CARRY) ? LEN_1 : LEN_2);
      rdchk("pc", ADDR_PC, {16'h0, exp_pc});
    end
    // Push from zero wraps the pointer; indirect push follows it
    wr(ADDR_FLAGS, 32'hb5);
    wr(ADDR_SP, 32'h0);
    rf_set(8'h40, 8'h4f);
    rf_set(8'h4f, 8'haa);
    exec({8'h00, 8'h40, OPC_PUSH_R}, CYC_LONG);
    rdchk("sp", ADDR_SP, 32'hffff);
    chk("stack", 32'h4f, {24'h0, stack.mem[16'hffff]});
    exec({8'h00, 8'h40, OPC_PUSH_IR}, CYC_LONG);
    rdchk("sp", ADDR_SP, 32'hfffe);
    chk("stack", 32'haa, {24'h0, stack.mem[16'hfffe]});
    // User stacks live in the register file, pointer first
    rf_set(8'h00, 8'h03);
    rf_set(8'h01, 8'h05);
    rf_set(8'h02, 8'h1a);
    exec({8'h01, 8'h00, OPC_STORE_DOWN}, CYC_LONG);
    rf_chk("ptr", 8'h00, 8'h02);
    rf_chk("dst", 8'h02, 8'h05);
    rf_set(8'h00, 8'h03);
    rf_set(8'h04, 8'h2a);
    exec({8'h01, 8'h00, OPC_STORE_UP}, CYC_LONG);
    rf_chk("ptr", 8'h00, 8'h04);
    rf_chk("dst", 8'h04, 8'h05);
    exp_pc = exp_pc + LEN_2 + LEN_2 + LEN_3 + LEN_3;
    rdchk("pc", ADDR_PC, {16'h0, exp_pc});
    // Return with both stack configurations
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL, k);
      wr(ADDR_SP, 32'h00fc);
      stack.mem[16'h00fc] = 8'h10 + 8'(k);
      stack.mem[16'h00fd] = 8'h1a;
      exec({16'h0, OPC_SUB_EXIT}, k ? CYC_EXIT_EXT : CYC_LONG);
      rdchk("pc", ADDR_PC, 32'h101a + (k << 8));
      chk("fetch", 32'h101a + (k << 8), {16'h0, fetch_addr});
      rdchk("sp", ADDR_SP, 32'h00fe);
    end
    rdchk("flags", ADDR_FLAGS, 32'hb5);
    // Unknown opcode: one byte, four cycles, marked bad in status
    exec({16'h0, 8'hff}, CYC_SHORT);
    rdchk("status", ADDR_STATUS, 32'h2);
    rdchk("pc", ADDR_PC, 32'h111b);
    // Unmapped address answers with an error
    apb(1'b0, 8'h20, 32'h0, r, er);
    chk("slverr", 32'h1, {31'h0, er});
    // Second reset in mid-run clears the architectural state
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdchk("pc", ADDR_PC, {16'h0, PC_RESET});
    rdchk("sp", ADDR_SP, {16'h0, SP_RESET});
    conclude();
  end
endmodule
